// ---- hw/css_debounce.sv ----
// synchroniser, bounce filter and single pulse for the start keys
module css_debounce
#(
  parameter int CYC = 10000
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // key
  input  wire logic raw,
  output logic      level,
  output logic      pulse
);
  logic        s1;
  logic        s2;
  logic [31:0] cnt;
  wire         differs = (s2 != level);
  wire         settled = differs && (cnt == 32'(CYC - 1));

  if (CYC < 2)
  begin : g_chk
    $error("css_debounce: CYC must be at least 2");
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
    end
    else
    begin
      s1 <= raw;
      s2 <= s1;
    end
  end

  // level moves only after the input held still for CYC cycles
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt   <= '0;
      level <= 1'b0;
      pulse <= 1'b0;
    end
    else
    begin
      cnt   <= (differs && !settled) ? cnt + 1'b1 : '0;
      level <= settled ? s2 : level;
      pulse <= settled && s2;
    end
  end
endmodule // css_debounce

// ---- hw/css_pkg.sv ----
// constants and types shared by the console start sequencer
package css_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS    = 100;
  localparam int PULSE_NS  = 100;
  localparam int CLEAR_NS  = 50;
  localparam int STEP_US   = 2;
  localparam int DEB_US    = 1000;
  localparam int PULSE_CYC = (PULSE_NS / CLK_NS < 1) ? 1 : PULSE_NS / CLK_NS;
  localparam int CLEAR_CYC = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_CYC  = (STEP_US * 1000) / CLK_NS;
  localparam int DEB_CYC   = (DEB_US * 1000) / CLK_NS;
  localparam int TMR_W     = 16;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] OFF_CTRL  = 12'h000;
  localparam logic [11:0] OFF_STAT  = 12'h004;
  localparam logic [11:0] OFF_POS   = 12'h008;
  localparam int CTRL_HALT   = 0;
  localparam int CTRL_SOFT   = 1;
  localparam int STAT_RUN    = 0;
  localparam int STAT_ST     = 1;
  localparam int STAT_PERMIT = 4;
  localparam int STAT_FETCH  = 5;
  localparam int STAT_TS1    = 6;
  localparam int POS_PC      = 0;
  localparam int POS_MA      = 12;
  localparam int POS_FB      = 24;
  localparam int POS_IF      = 29;
  localparam logic [11:0] PC_RST = 12'h000;
  localparam logic [11:0] MA_RST = 12'h000;
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {CSS_IDLE, CSS_A, CSS_B, CSS_C} css_state_t;
endpackage

// ---- hw/css_sequencer.sv ----
// console start sequencer: key to manual states to run, with APB access
//
// Behaviour
// - next-instruction permit high unless defer or another inhibit is set
// - combined start key is filtered so bounce gives one start
// - debounced key gives one 100 ns pulse, enters state A only if stopped
// - about 50 ns into state A, clear major states unless continue
// - same pulse clears H and skip flip-flops unless continue
// - state B with left start: switch 00 sets bit 03, 01 sets bit 04
// - state B with left start: field switches set extended bits 0-2
// - first timing pulse comes about 2 us after state B begins
// - first timing pulse with a start key loads PC from left switches
// - first timing pulse sets state C and clears state B
// - fetch-set is permit with no interrupt, tape or data break pending
// - fetch-set, state B clear and time state one select PC to address
// - second timing pulse follows first by about 2 us, clears state C
// - second timing pulse loads memory address unless I/O preset
// - second timing pulse sets run unless I/O preset
// - a timing cycle starts only with run, cycle done and memory idle
// - time state one held while stopped and forced by I/O preset
module css_sequencer
  import css_pkg::*;
#(
  parameter int DEB_CYCLES = DEB_CYC,
  parameter int N_KEYS     = 3
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // console switches, asynchronous
  input  wire logic [N_KEYS-1:0] startKeys,
  input  wire logic        keyStartLs,
  input  wire logic        keyCont,
  input  wire logic        keyIoPreset,
  input  wire logic [11:0] leftSwitches,
  input  wire logic [2:0]  fieldSwitches,
  // processor conditions, same clock
  input  wire logic        deferPending,
  input  wire logic [3:0]  permitInhibit,
  input  wire logic        interruptReq,
  input  wire logic        tapeReq,
  input  wire logic        breakReq,
  input  wire logic        cycleDone,
  input  wire logic        memIdle,
  input  wire logic        timeStateProc,
  input  wire logic        stopReq,
  // sequencer outputs
  output logic             manualStateA,
  output logic             manualStateB,
  output logic             manualStateC,
  output logic             manualPulseA,
  output logic             manualPulseB,
  output logic             manualPulseC,
  output logic             clearMajorStates,
  output logic             clearSkips,
  output logic             pcLoad,
  output logic [11:0]      pc,
  output logic [4:0]       fieldBuffer,
  output logic [1:0]       instrField,
  output logic             nextInstrPermit,
  output logic             fetchSet,
  output logic             counterToAddressSelect,
  output logic             marLoad,
  output logic [11:0]      memAddr,
  output logic             run,
  output logic             cycleStart,
  output logic             timeStateOne
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a[11:2] == o[11:2]);
  endfunction

  if (N_KEYS < 1 || DEB_CYCLES < 2 || STEP_CYC >= 2 ** TMR_W)
  begin : g_chk
    $error("css_sequencer: parameter out of range");
  end

  // ----------------------------------------
  // switch synchronisers
  // ----------------------------------------
  localparam int SW_W = 18;
  logic [SW_W-1:0] swMeta;
  logic [SW_W-1:0] swSync;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      swMeta <= '0;
      swSync <= '0;
    end
    else
    begin
      swMeta <= {keyStartLs, keyCont, keyIoPreset, fieldSwitches,
                 leftSwitches};
      swSync <= swMeta;
    end
  end

  wire        lsKey   = swSync[17];
  wire        contKey = swSync[16];
  wire        ioKey   = swSync[15];
  wire [2:0]  ifSw    = swSync[14:12];
  wire [11:0] left_switch_value     = swSync[11:0];

  // ----------------------------------------
  // start key, combined then debounced
  // ----------------------------------------
  // the raw keys are merged before the filter, so one filter serves all
  wire rawStart = (|startKeys) | keyStartLs;
  logic keyLevel;
  logic keyPulse;

  css_debounce #(.CYC(DEB_CYCLES)) u_deb
  (
    .clk   (clk),
    .rst_n (rst_n),
    .raw   (rawStart),
    .level (keyLevel),
    .pulse (keyPulse)
  );

  // ----------------------------------------
  // register interface
  // ----------------------------------------
  logic softStart;
  logic haltReq;
  wire  setupPh  = psel && !penable;
  wire  accessOk = psel && penable && pready;
  wire  hitCtrl  = hit(paddr, OFF_CTRL);
  wire  hitStat  = hit(paddr, OFF_STAT);
  wire  hitPos   = hit(paddr, OFF_POS);
  wire  mapped   = hitCtrl || hitStat || hitPos;
  wire  wrCtrl   = accessOk && pwrite && hitCtrl;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  css_state_t state;
  css_state_t next_state;
  css_step_if step ();

  css_timer u_tmr
  (
    .clk   (clk),
    .rst_n (rst_n),
    .step  (step.tmr)
  );

  wire startAny  = keyPulse || softStart;
  wire startFire = startAny && !run && (state == CSS_IDLE);
  wire fireA     = (state == CSS_A) && step.tick;
  wire fireB     = (state == CSS_B) && step.tick;
  wire fireC     = (state == CSS_C) && step.tick;
  wire lsEnable  = (state == CSS_B) && lsKey;
  wire keyActive = keyLevel || lsKey;
  wire goRun     = fireC && !ioKey;

  // one state at a time, strictly A then B then C then idle
  always_comb
  begin
    next_state = state;
    case (state)
      CSS_IDLE: if (startFire) next_state = CSS_A;
      CSS_A:    if (fireA) next_state = CSS_B;
      CSS_B:    if (fireB) next_state = CSS_C;
      CSS_C:    if (fireC) next_state = CSS_IDLE;
      default:  next_state = CSS_IDLE;
    endcase
  end

  assign step.kick = startFire || fireA || fireB;
  assign step.load = startFire ? TMR_W'(CLEAR_CYC) : TMR_W'(STEP_CYC);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state <= CSS_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      manualStateA <= 1'b0;
      manualStateB <= 1'b0;
      manualStateC <= 1'b0;
      manualPulseA <= 1'b0;
      manualPulseB <= 1'b0;
      manualPulseC <= 1'b0;
    end
    else
    begin
      manualStateA <= (next_state == CSS_A);
      manualStateB <= (next_state == CSS_B);
      manualStateC <= (next_state == CSS_C);
      manualPulseA <= fireA;
      manualPulseB <= fireB;
      manualPulseC <= fireC;
    end
  end

  // ----------------------------------------
  // effects of the manual pulses
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      clearMajorStates <= 1'b0;
      clearSkips       <= 1'b0;
      pcLoad           <= 1'b0;
      marLoad          <= 1'b0;
    end
    else
    begin
      clearMajorStates <= fireA && !contKey;
      clearSkips       <= fireA && !contKey;
      pcLoad           <= fireB && keyActive;
      marLoad          <= goRun;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pc <= PC_RST;
    else if (fireB && keyActive)
      pc <= left_switch_value;
  end

  // only the high ten bits travel when the counter feeds the address; the low two are zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      memAddr <= MA_RST;
    else if (goRun)
      memAddr <= {pc[11:2], 2'b00};
  end

  // field bits are set only; nothing here clears them after reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fieldBuffer[4:3] <= 2'b00;
      instrField       <= 2'b00;
    end
    else if (lsEnable)
    begin
      fieldBuffer[4:3] <= fieldBuffer[4:3] | {left_switch_value[1], left_switch_value[0]};
      instrField       <= instrField | {left_switch_value[1], left_switch_value[0]};
    end
  end

  for (genvar i = 0; i < 3; i++)
  begin : g_ext
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        fieldBuffer[i] <= 1'b0;
      else if (lsEnable && ifSw[i])
        fieldBuffer[i] <= 1'b1;
    end
  end

  // set wins over halt so a start in the same cycle is not lost
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      run <= 1'b0;
    else if (goRun)
      run <= 1'b1;
    else if (stopReq || haltReq)
      run <= 1'b0;
  end

  // ----------------------------------------
  // processor side conditions
  // ----------------------------------------
  wire permitNow = !(deferPending || (|permitInhibit));
  wire fetchNow  = permitNow && !interruptReq && !tapeReq && !breakReq;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      nextInstrPermit        <= 1'b0;
      fetchSet               <= 1'b0;
      counterToAddressSelect <= 1'b0;
      cycleStart             <= 1'b0;
      timeStateOne           <= 1'b1;
    end
    else
    begin
      nextInstrPermit        <= permitNow;
      fetchSet               <= fetchNow;
      counterToAddressSelect <= fetchNow && (next_state != CSS_B) &&
                                timeStateOne;
      cycleStart             <= run && cycleDone && memIdle;
      timeStateOne           <= !run || ioKey || timeStateProc;
    end
  end

  // ----------------------------------------
  // apb slave, answers in the first access cycle
  // ----------------------------------------
  wire [31:0] statWord = {25'h0, timeStateOne, fetchSet, nextInstrPermit,
                          manualStateC, manualStateB, manualStateA, run};
  wire [31:0] posWord  = {1'b0, instrField, fieldBuffer, 12'h000, pc} |
                         {8'h00, memAddr, 12'h000};
  wire [31:0] rdMux    = hitCtrl ? 32'h0000_0000 :
                         hitStat ? statWord : hitPos ? posWord : 32'h0;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setupPh;
      pslverr <= setupPh && !mapped;
      prdata  <= (setupPh && !pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      softStart <= 1'b0;
      haltReq   <= 1'b0;
    end
    else
    begin
      softStart <= wrCtrl && pwdata[CTRL_SOFT];
      haltReq   <= wrCtrl && pwdata[CTRL_HALT];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_permit_follows: assert property (
    (deferPending || (|permitInhibit)) |=> !nextInstrPermit)
    else $error("permit high while inhibited");
  a_start_gated: assert property (
    (state == CSS_IDLE && run) |=> state == CSS_IDLE)
    else $error("start taken while running");
  a_clear_states: assert property (
    (fireA && !contKey) |=> clearMajorStates && clearSkips)
    else $error("major states not cleared");
  a_cont_keeps: assert property (
    (fireA && contKey) |=> !clearSkips && !clearMajorStates)
    else $error("clear with continue pressed");
  a_field_set: assert property (
    (lsEnable && left_switch_value[0]) |=> fieldBuffer[3] && instrField[0])
    else $error("field bit 03 not set");
  a_step_time: assert property (
    $rose(step.kick && state == CSS_A) |-> ##(STEP_CYC + 1) fireB)
    else $error("first timing pulse late or early");
  a_pc_load: assert property (
    (fireB && keyActive) |=> pcLoad && pc == $past(left_switch_value))
    else $error("pc not loaded from switches");
  a_run_set: assert property (
    (fireC && !ioKey) |=> run && marLoad)
    else $error("run not set by last pulse");
  a_preset_hold: assert property (
    (fireC && ioKey) |=> !marLoad)
    else $error("address loaded under preset");
  a_cycle_gate: assert property (
    cycleStart |-> $past(run && cycleDone && memIdle))
    else $error("cycle start without all three");
  a_ts_stopped: assert property (
    !run |=> timeStateOne)
    else $error("time state one dropped while stopped");
  a_one_state: assert property (
    $onehot0({manualStateA, manualStateB, manualStateC}))
    else $error("manual states overlap");

  c_full_start: cover property (fireC && !ioKey);
  c_cont_start: cover property (fireA && contKey);
  c_soft_start: cover property (softStart && state == CSS_IDLE);
endmodule // css_sequencer

// ---- hw/css_step_if.sv ----
// carrier between the sequencer and its step timer
interface css_step_if;
  import css_pkg::*;
  logic             kick;
  logic [TMR_W-1:0] load;
  logic             tick;
  modport ctl (output kick, output load, input tick);
  modport tmr (input kick, input load, output tick);
endinterface

// ---- hw/css_timer.sv ----
// one-shot step timer, ticks once after a loaded count
module css_timer
  import css_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sequencer side
  css_step_if.tmr  step
);
  logic [TMR_W-1:0] cnt;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt <= '0;
    else if (step.kick)
      cnt <= step.load;
    else if (cnt != '0)
      cnt <= cnt - 1'b1;
  end

  // a new kick kills a stale tick
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      step.tick <= 1'b0;
    else
      step.tick <= (cnt == 16'h0001) && !step.kick;
  end
endmodule // css_timer

// ---- tb/css_console.sv ----
// operator at the console: start keys with contact chatter
module css_console
(
  // clock
  input  wire logic       clk,
  // operator intent, one bit a key, left-switch start on top
  input  wire logic [3:0] press,
  // raw key lines
  output logic [2:0]      startKeys,
  output logic            keyStartLs
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] held = 4'h0;
  logic [3:0] prev = 4'h0;
  logic [1:0] cnt  = 2'h0;
  // --------------------------------
  // bounce
  // --------------------------------
  // every key edge chatters for three cycles, so a lone sample lies
  always @(posedge clk)
  begin
    if (press != held)
    begin
      prev <= held;
      held <= press;
      cnt  <= 2'h3;
    end
    else if (cnt != 2'h0)
      cnt <= cnt - 2'h1;
  end
  assign {keyStartLs, startKeys} =
    held ^ ((held ^ prev) & {4{cnt[0]}});
endmodule // css_console

// ---- tb/tb.sv ----
// self-checking bench for the console start sequencer
module tb
  import css_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [2:0] key;
    logic cont, iop, ld, go;
    logic [11:0] left_switch_value;
    logic [2:0] fsw;
  } css_row_t;
  logic clk = 1'b0, rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000, leftSwitches = 12'h000, pc, memAddr;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, keyStartLs;
  logic [3:0] press = 4'h0, permitInhibit = 4'h0;
  logic [2:0] startKeys, fieldSwitches = 3'h0;
  logic keyCont = 1'b0, keyIoPreset = 1'b0, deferPending = 1'b0;
  logic interruptReq = 1'b0, tapeReq = 1'b0, breakReq = 1'b0;
  logic cycleDone = 1'b0, memIdle = 1'b0;
  logic timeStateProc = 1'b0, stopReq = 1'b0;
  logic manualStateA, manualStateB, manualStateC, manualPulseA;
  logic manualPulseB, manualPulseC, clearMajorStates, clearSkips;
  logic pcLoad, nextInstrPermit, fetchSet, counterToAddressSelect;
  logic marLoad, run, cycleStart, timeStateOne;
  logic [4:0] fieldBuffer, expFb = 5'h00;
  logic [1:0] instrField, expIf = 2'h0;
  logic [11:0] expPc = 12'h000, expMa = 12'h000;
  int err_count = 0, n_compared = 0;
  css_row_t rows [5] = '{
    '{3'h0, 1'b0, 1'b0, 1'b1, 1'b1, 12'hABC, 3'h5},
    '{3'h3, 1'b0, 1'b0, 1'b1, 1'b1, 12'h003, 3'h6},
    '{3'h1, 1'b1, 1'b0, 1'b1, 1'b1, 12'h555, 3'h7},
    '{3'h2, 1'b0, 1'b1, 1'b1, 1'b0, 12'hFFF, 3'h1},
    '{3'h4, 1'b0, 1'b0, 1'b0, 1'b1, 12'h123, 3'h2}};
  css_sequencer #(.DEB_CYCLES(4)) i_dut (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .startKeys,
    .keyStartLs, .keyCont, .keyIoPreset, .leftSwitches, .fieldSwitches,
    .deferPending, .permitInhibit, .interruptReq, .tapeReq, .breakReq,
    .cycleDone, .memIdle, .timeStateProc, .stopReq, .manualStateA,
    .manualStateB, .manualStateC, .manualPulseA, .manualPulseB,
    .manualPulseC, .clearMajorStates, .clearSkips, .pcLoad, .pc,
    .fieldBuffer, .instrField, .nextInstrPermit, .fetchSet,
    .counterToAddressSelect, .marLoad, .memAddr, .run, .cycleStart,
    .timeStateOne);
  css_console i_con (.clk, .press, .startKeys, .keyStartLs);
  initial
  begin
    forever #50 clk = ~clk;
  end
  // --------------------------------
  // helpers
  // --------------------------------
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_val(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, g);
    chk_val(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic ne(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bounded wait; a level seen at the falling edge stands at the next rise
  task automatic wait_hi(ref logic s);
    int k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end while (s !== 1'b1 && k < 40);
    if (s !== 1'b1)
    begin
      err_count++;
      complete_run();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    wait_hi(pready);
    @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run_row(input css_row_t r);
    @(posedge clk);
    keyCont       <= r.cont;
    keyIoPreset   <= r.iop;
    leftSwitches  <= r.left_switch_value;
    fieldSwitches <= r.fsw;
    ne(6);
    if (r.key == 3'h4)
      apb(1'b1, OFF_CTRL, 32'h2);
    else
    begin
      @(posedge clk);
      press <= 4'h1 << r.key;
    end
    wait_hi(manualStateA);
    ne(2);
    chk_bit("pulseA", 1'b1, manualPulseA);
    chk_bit("clrMajor", !r.cont, clearMajorStates);
    chk_bit("clrSkips", !r.cont, clearSkips);
    chk_bit("stateA", 1'b0, manualStateA);
    chk_bit("stateB", 1'b1, manualStateB);
    ne(10);
    chk_bit("pcToMaB", 1'b0, counterToAddressSelect);
    ne(STEP_CYC - 10);
    chk_bit("pulseBearly", 1'b0, manualPulseB);
    ne(1);
    chk_bit("pulseB", 1'b1, manualPulseB);
    chk_bit("pcLoad", r.ld, pcLoad);
    chk_bit("stateC", 1'b1, manualStateC);
    chk_bit("stateBoff", 1'b0, manualStateB);
    if (r.key == 3'h3)
    begin
      expFb = expFb | {r.left_switch_value[1:0], r.fsw};
      expIf = expIf | r.left_switch_value[1:0];
    end
    if (r.ld)
      expPc = r.left_switch_value;
    if (r.go)
      expMa = {expPc[11:2], 2'h0};
    ne(1);
    chk_val("pc", expPc, pc);
    chk_val("fieldBuf", expFb, fieldBuffer);
    chk_val("instrField", expIf, instrField);
    ne(STEP_CYC);
    chk_bit("pulseC", 1'b1, manualPulseC);
    chk_bit("marLoad", r.go, marLoad);
    chk_bit("stateCoff", 1'b0, manualStateC);
    ne(1);
    chk_bit("run", r.go, run);
    chk_val("memAddr", expMa, memAddr);
    chk_bit("ts1", !r.go, timeStateOne);
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    ne(1);
    chk_bit("ts1rst", 1'b1, timeStateOne);
    chk_bit("runRst", 1'b0, run);
    for (int j = 0; j < 8; j++)
    begin
      @(posedge clk);
      {breakReq, tapeReq, interruptReq, permitInhibit, deferPending}
        <= 8'h01 << j;
      ne(3);
      chk_bit("permit", j > 4, nextInstrPermit);
      chk_bit("fetchSet", 1'b0, fetchSet);
      chk_bit("pcToMa", 1'b0, counterToAddressSelect);
    end
    @(posedge clk);
    {breakReq, tapeReq, interruptReq, permitInhibit, deferPending} <= 8'h00;
    ne(3);
    chk_bit("fetchSetOn", 1'b1, fetchSet);
    chk_bit("pcToMaOn", 1'b1, counterToAddressSelect);
    $display("conditions done");
    foreach (rows[i])
    begin
      run_row(rows[i]);
      if (i == 0)
      begin
        apb(1'b1, OFF_CTRL, 32'h2);
        ne(4);
        chk_bit("refused", 1'b0, manualStateA);
        apb(1'b0, OFF_STAT, 32'h0);
        chk_val("statRun", 32'h1, rd & 32'h1);
        for (int j = 0; j < 4; j++)
        begin
          @(posedge clk);
          cycleDone     <= j[0];
          memIdle       <= j[1];
          timeStateProc <= (j == 1);
          ne(2);
          chk_bit("cycStart", j == 3, cycleStart);
          chk_bit("ts1Run", j == 1, timeStateOne);
        end
      end
      // one row stops through the processor, the others through software
      if (i == 1)
      begin
        @(posedge clk);
        stopReq <= 1'b1;
        @(posedge clk);
        stopReq <= 1'b0;
      end
      else
        apb(1'b1, OFF_CTRL, 32'h1);
      @(posedge clk);
      press <= 4'h0;
      ne(3);
      chk_bit("halted", 1'b0, run);
      chk_bit("cycStop", 1'b0, cycleStart);
      ne(12);
      $display("row %0d done", i);
    end
    apb(1'b0, OFF_STAT, 32'h0);
    chk_val("stat", 32'h70, rd);
    apb(1'b0, OFF_POS, 32'h0);
    chk_val("pos", {1'b0, expIf, expFb, expMa, expPc}, rd);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk_val("ctrlRead", 32'h0, rd);
    apb(1'b0, 12'h00C, 32'h0);
    chk_bit("slverr", 1'b1, er);
    chk_val("unmapped", 32'h0, rd);
    $display("registers done");
    // reset in mid-sequence must leave no state half set
    apb(1'b1, OFF_CTRL, 32'h2);
    wait_hi(manualStateA);
    ne(8);
    @(posedge clk);
    rst_n <= 1'b0;
    ne(2);
    chk_bit("rstStateB", 1'b0, manualStateB);
    chk_val("rstFb", 32'h0, {27'h0, fieldBuffer});
    @(posedge clk);
    rst_n <= 1'b1;
    ne(2);
    chk_bit("rstTs1", 1'b1, timeStateOne);
    chk_bit("rstIdle", 1'b0, manualStateA);
    chk_bit("rstRun", 1'b0, run);
    $display("reset done");
    complete_run();
  end
endmodule // tb
